//--- core/ctr_edge_map.vh
// Address map, field positions and reset values of the counter and edge block
`ifndef CTR_EDGE_MAP_VH
`define CTR_EDGE_MAP_VH
`define ADDR_PORT_A 12'h080
`define ADDR_PORT_B 12'h081
`define ADDR_PORT_C 12'h082
`define ADDR_PORT_D 12'h083
`define ADDR_RELOAD_UPPER 12'h084
`define ADDR_RELOAD_LOWER 12'h085
`define ADDR_COUNT_UPPER 12'h086
`define ADDR_COUNT_LOWER 12'h087
`define ADDR_PRESET 12'h088
`define ADDR_CLR_RISE 12'h089
`define ADDR_CLR_FALL 12'h08a
`define ADDR_CONTROL 12'h08f
`define CTL_OVF_BIT 7
`define CTL_RISE_BIT 6
`define CTL_FALL_BIT 5
`define CTL_CNT_IE_BIT 4
`define CTL_RISE_IE_BIT 3
`define CTL_FALL_IE_BIT 2
`define CTL_MODE_HI_BIT 1
`define CTL_MODE_LO_BIT 0
`define CTL_WRITE_MASK 8'h1f
`define CTL_RESET 8'h00
`define PORT_RESET 8'hff
`define MODE_INTERVAL 2'h0
`define MODE_PULSE_GEN 2'h1
`define MODE_EVENT 2'h2
`define MODE_WIDTH 2'h3
`endif

//--- core/ctr_edge_io.v
// Counter/latch, edge detectors, control register and four ports
`include "ctr_edge_map.vh"
`default_nettype none

module ctr_edge_io #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_reset_n,
   // Processor access
   input wire [11:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   // Interrupt request
   output reg o_irq,
   // Port pins
   input wire [7:0] i_port_a,
   input wire [7:0] i_port_b,
   input wire [7:0] i_port_c,
   input wire [7:0] i_port_d,
   output reg [7:0] o_port_a_oe,
   output reg [7:0] o_port_b_oe,
   output reg [7:0] o_port_c_oe,
   output reg [7:0] o_port_d_oe,
   // Counter line pin
   input wire i_counter_io_line,
   output reg o_counter_io_line_oe
);

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   wire [32:0] pin_raw = {i_counter_io_line, i_port_d, i_port_c,
      i_port_b, i_port_a};
   reg [32:0] sync1_q;
   reg [32:0] sync2_q;
   reg [32:0] sync3_q;
   reg [32:0] pin_q;
   reg [32:0] pin_prev_q;
   wire [32:0] pin_d;
   genvar g;
   generate
      for (g = 0; g < 33; g = g + 1) begin : g_pin
         assign pin_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] :
            pin_q[g];
      end
   endgenerate

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1_q <= {33{1'b1}};
         sync2_q <= {33{1'b1}};
         sync3_q <= {33{1'b1}};
         pin_q <= {33{1'b1}};
         pin_prev_q <= {33{1'b1}};
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q <= pin_d;
         pin_prev_q <= pin_q;
      end
   end

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   wire wr_port_a = i_wr && (i_addr == `ADDR_PORT_A);
   wire wr_port_b = i_wr && (i_addr == `ADDR_PORT_B);
   wire wr_port_c = i_wr && (i_addr == `ADDR_PORT_C);
   wire wr_port_d = i_wr && (i_addr == `ADDR_PORT_D);
   wire wr_rel_hi = i_wr && (i_addr == `ADDR_RELOAD_UPPER);
   wire wr_rel_lo = i_wr && (i_addr == `ADDR_RELOAD_LOWER);
   wire wr_preset = i_wr && (i_addr == `ADDR_PRESET);
   wire wr_clr_rise = i_wr && (i_addr == `ADDR_CLR_RISE);
   wire wr_clr_fall = i_wr && (i_addr == `ADDR_CLR_FALL);
   wire wr_ctl = i_wr && (i_addr == `ADDR_CONTROL);
   wire rd_cnt_lo = i_rd && (i_addr == `ADDR_COUNT_LOWER);

   // -------------------------------------------------------------
   // Edge detection
   // -------------------------------------------------------------
   // Rising edge on line 0
   wire rise_evt = pin_q[0] && !pin_prev_q[0];
   wire fall_evt = !pin_q[1] && pin_prev_q[1];
   wire counter_io_line_rise = pin_q[32] && !pin_prev_q[32];

   // -------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------
   reg [7:0] ctl_q;
   reg [7:0] ctl_d;
   reg [WIDTH-1:0] latch_q;
   reg [WIDTH-1:0] latch_d;
   reg [WIDTH-1:0] count_q;
   reg [WIDTH-1:0] count_d;
   reg counter_io_line_level_q;
   reg counter_io_line_level_d;
   reg dec;
   reg ovf;
   wire [1:0] mode = {ctl_q[`CTL_MODE_HI_BIT], ctl_q[`CTL_MODE_LO_BIT]};

   // -------------------------------------------------------------
   // Counter and latch
   // -------------------------------------------------------------
   always @* begin
      latch_d = latch_q;
      count_d = count_q;
      counter_io_line_level_d = counter_io_line_level_q;
      dec = 1'b0;
      case (mode)
         `MODE_INTERVAL: dec = 1'b1;
         `MODE_PULSE_GEN: dec = 1'b1;
         `MODE_EVENT: dec = counter_io_line_rise;
         `MODE_WIDTH: dec = !pin_q[32];
         default: dec = 1'b0;
      endcase
      ovf = dec && (count_q == {WIDTH{1'b0}});
      if (wr_rel_hi || wr_preset) begin
         latch_d[WIDTH-1:8] = i_wdata;
      end
      if (wr_rel_lo) begin
         latch_d[7:0] = i_wdata;
      end
      // Preset uses freshly stored upper byte
      if (wr_preset) begin
         count_d = {i_wdata, latch_q[7:0]};
      end else if (ovf) begin
         count_d = latch_q;
      end else if (dec) begin
         count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
      if (mode == `MODE_PULSE_GEN) begin
         if (ovf != wr_preset) begin
            counter_io_line_level_d = !counter_io_line_level_q;
         end
      end else begin
         counter_io_line_level_d = 1'b1;
      end
   end

   always @(posedge i_clk_sys) begin
      latch_q <= latch_d;
      count_q <= count_d;
   end

   always @* begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         ctl_d = (ctl_q & ~`CTL_WRITE_MASK) | (i_wdata & `CTL_WRITE_MASK);
      end
      if (rd_cnt_lo || wr_preset) begin
         ctl_d[`CTL_OVF_BIT] = 1'b0;
      end
      if (wr_clr_rise) begin
         ctl_d[`CTL_RISE_BIT] = 1'b0;
      end
      if (wr_clr_fall) begin
         ctl_d[`CTL_FALL_BIT] = 1'b0;
      end
      if (ovf) begin
         ctl_d[`CTL_OVF_BIT] = 1'b1;
      end
      if (rise_evt) begin
         ctl_d[`CTL_RISE_BIT] = 1'b1;
      end
      if (fall_evt) begin
         ctl_d[`CTL_FALL_BIT] = 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Ports, counter line and interrupt
   // -------------------------------------------------------------
   reg [7:0] port_a_q;
   reg [7:0] port_b_q;
   reg [7:0] port_c_q;
   reg [7:0] port_d_q;
   wire [7:0] ctl_next_irq = ctl_d;
   wire irq_d = (ctl_next_irq[`CTL_RISE_BIT] &&
      ctl_next_irq[`CTL_RISE_IE_BIT]) ||
      (ctl_next_irq[`CTL_FALL_BIT] && ctl_next_irq[`CTL_FALL_IE_BIT]) ||
      (ctl_next_irq[`CTL_OVF_BIT] && ctl_next_irq[`CTL_CNT_IE_BIT]);
   wire [1:0] mode_d = {ctl_d[`CTL_MODE_HI_BIT], ctl_d[`CTL_MODE_LO_BIT]};

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctl_q <= `CTL_RESET;
         counter_io_line_level_q <= 1'b1;
         o_counter_io_line_oe <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         counter_io_line_level_q <= counter_io_line_level_d;
         // Output only in modes 0 and 1
         o_counter_io_line_oe <= !mode_d[1] && !counter_io_line_level_d;
      end
   end

   // -------------------------------------------------------------
   // Interrupt request
   // -------------------------------------------------------------
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= irq_d;
      end
   end

   // -------------------------------------------------------------
   // Port output registers
   // -------------------------------------------------------------
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         port_a_q <= `PORT_RESET;
         o_port_a_oe <= 8'h00;
      end else begin
         if (wr_port_a) begin
            port_a_q <= i_wdata;
         end
         o_port_a_oe <= wr_port_a ? ~i_wdata : ~port_a_q;
      end
   end

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         port_b_q <= `PORT_RESET;
         o_port_b_oe <= 8'h00;
      end else begin
         if (wr_port_b) begin
            port_b_q <= i_wdata;
         end
         o_port_b_oe <= wr_port_b ? ~i_wdata : ~port_b_q;
      end
   end

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         port_c_q <= `PORT_RESET;
         o_port_c_oe <= 8'h00;
      end else begin
         if (wr_port_c) begin
            port_c_q <= i_wdata;
         end
         o_port_c_oe <= wr_port_c ? ~i_wdata : ~port_c_q;
      end
   end

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         port_d_q <= `PORT_RESET;
         o_port_d_oe <= 8'h00;
      end else begin
         if (wr_port_d) begin
            port_d_q <= i_wdata;
         end
         o_port_d_oe <= wr_port_d ? ~i_wdata : ~port_d_q;
      end
   end

   // -------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         // Counter reads do not disturb it
         case (i_addr)
            `ADDR_PORT_A: o_rdata <= pin_q[7:0];
            `ADDR_PORT_B: o_rdata <= pin_q[15:8];
            `ADDR_PORT_C: o_rdata <= pin_q[23:16];
            `ADDR_PORT_D: o_rdata <= pin_q[31:24];
            `ADDR_COUNT_UPPER: o_rdata <= count_q[WIDTH-1:8];
            `ADDR_COUNT_LOWER: o_rdata <= count_q[7:0];
            `ADDR_CONTROL: o_rdata <= ctl_q;
            default: o_rdata <= 8'h00;
         endcase
      end
   end

endmodule // ctr_edge_io
`default_nettype wire

//--- tb/ctr_edge_io_sva.sv
// Assertions on the counter, edge and port block
`include "ctr_edge_map.vh"
`default_nettype none
module ctr_edge_io_sva (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // Processor access
   input wire logic [11:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   // Watched outputs
   input wire logic o_irq,
   input wire logic [7:0] o_port_a_oe,
   input wire logic o_counter_io_line_oe
);
   logic [4:0] ctl_q;
   wire wr_ctl = i_wr && i_addr == `ADDR_CONTROL;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // ----
   // Control bits as written
   // ----
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) ctl_q <= 5'h00;
      else if (wr_ctl) ctl_q <= i_wdata[4:0];
   end
   rst_quiet_a: assert property (
      $rose(i_reset_n) |-> !o_irq && o_port_a_oe == 8'h00
         && !o_counter_io_line_oe) else $error("outputs active at reset");
   read_wo_a: assert property (
      i_rd && i_addr == `ADDR_RELOAD_UPPER |=> o_rdata == 8'h00)
      else $error("write-only read not zero");
   port_oe_a: assert property (
      i_wr && i_addr == `ADDR_PORT_A |-> ##2
         o_port_a_oe == ~$past(i_wdata, 2)) else $error("port drive wrong");
   ctl_read_a: assert property (
      wr_ctl ##1 (i_rd && i_addr == `ADDR_CONTROL) |=>
         o_rdata[4:0] == $past(i_wdata[4:0], 2)) else $error("control bits");
   counter_io_line_input_a: assert property (
      ctl_q[1] && $past(ctl_q[1]) |-> !o_counter_io_line_oe)
      else $error("counter line driven in input mode");
   irq_masked_a: assert property (
      ctl_q[4:2] == 3'h0 && $past(ctl_q[4:2]) == 3'h0 |-> !o_irq)
      else $error("irq with all enables off");
   pulse_toggle_a: assert property (
      ctl_q[1:0] == 2'h1 && i_wr && i_addr == `ADDR_PRESET |=>
         o_counter_io_line_oe != $past(o_counter_io_line_oe))
      else $error("preset did not toggle line");
   rise_clear_a: assert property (
      ctl_q[4:2] == 3'h2 && i_wr && i_addr == `ADDR_CLR_RISE |-> ##2 !o_irq)
      else $error("rise clear kept irq");
   fall_clear_a: assert property (
      ctl_q[4:2] == 3'h1 && i_wr && i_addr == `ADDR_CLR_FALL |-> ##2 !o_irq)
      else $error("fall clear kept irq");
   cover property (o_irq);
   cover property (ctl_q[1:0] == 2'h2 && i_rd);
   cover property ($rose(o_counter_io_line_oe));
endmodule // ctr_edge_io_sva
bind ctr_edge_io ctr_edge_io_sva i_sva (.i_clk_sys(i_clk_sys),
   .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
   .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_port_a_oe(o_port_a_oe), .o_counter_io_line_oe(o_counter_io_line_oe));
`default_nettype wire

//--- tb/ext_pins.sv
// Pull-ups on the port and counter lines, outside drivers on port A and the counter line
`default_nettype none
module ext_pins (
   // Device enables
   input wire logic [31:0] i_oe,
   input wire logic i_counter_io_line_oe,
   // Outside drivers pulling low
   input wire logic [7:0] i_pull_a,
   input wire logic i_pull_counter_io_line,
   // Resolved levels
   output logic [31:0] o_pins,
   output logic o_counter_io_line
);
   timeunit 1ns;
   timeprecision 1ns;
   assign o_pins = ~(i_oe | {24'h0, i_pull_a});
   assign o_counter_io_line = ~(i_counter_io_line_oe | i_pull_counter_io_line);
endmodule // ext_pins
`default_nettype wire

//--- tb/tb_mcu_counter_edge_io.sv
// Self-checking bench of the counter, edge and port block
`include "ctr_edge_map.vh"
`default_nettype none
module tb_mcu_counter_edge_io;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, wr, rd, pc, coe, counter_io_line, irq;
   logic [11:0] addr;
   logic [7:0] wd, pa, rdata;
   wire [31:0] oe;
   logic [31:0] pins;
   int errors, check_count;
   ctr_edge_io i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr),
      .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdata), .o_irq(irq),
      .i_port_a(pins[7:0]), .i_port_b(pins[15:8]), .i_port_c(pins[23:16]),
      .i_port_d(pins[31:24]), .o_port_a_oe(oe[7:0]), .o_port_b_oe(oe[15:8]),
      .o_port_c_oe(oe[23:16]), .o_port_d_oe(oe[31:24]),
      .i_counter_io_line(counter_io_line), .o_counter_io_line_oe(coe));
   ext_pins i_pins (.i_oe(oe), .i_counter_io_line_oe(coe), .i_pull_a(pa),
      .i_pull_counter_io_line(pc), .o_pins(pins), .o_counter_io_line(counter_io_line));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [7:0] m,
         input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, exp);
   endtask
   task automatic t_reset();
      wr_reg(`ADDR_RELOAD_UPPER, 8'h00);
      wr_reg(`ADDR_RELOAD_LOWER, 8'h20);
      wr_reg(`ADDR_PRESET, 8'h00);
      rd_reg(`ADDR_CONTROL, 8'h7f, 8'h00);
      rd_reg(`ADDR_PORT_A, 8'hff, 8'hff);
      rd_reg(`ADDR_RELOAD_UPPER, 8'hff, 8'h00);
      rd_reg(12'h08b, 8'hff, 8'h00);
      @(posedge clk);
      wr <= 1'b1;
      addr <= `ADDR_CONTROL;
      wd <= 8'hff;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & 8'h1f, 8'h1f);
      wr_reg(`ADDR_CONTROL, 8'h00);
   endtask
   task automatic t_ports();
      wr_reg(`ADDR_PORT_A, 8'hf3);
      wait_n(4);
      #1;
      chk(oe[7:0], 8'h0c);
      rd_reg(`ADDR_PORT_A, 8'hff, 8'hf3);
      wr_reg(`ADDR_PORT_A, 8'hff);
      chk(oe[15:8] | oe[23:16] | oe[31:24], 8'h00);
      wr_reg(`ADDR_PORT_D, 8'h5a);
      wait_n(5);
      #1;
      chk(oe[31:24], 8'ha5);
      rd_reg(`ADDR_PORT_D, 8'hff, 8'h5a);
      wr_reg(`ADDR_PORT_D, 8'hff);
   endtask
   task automatic t_overflow();
      wr_reg(`ADDR_CONTROL, 8'h10);
      wait_n(100);
      #1;
      chk({7'h0, coe}, 8'h00);
      rd_reg(`ADDR_COUNT_UPPER, 8'hff, 8'h00);
      rd_reg(`ADDR_CONTROL, 8'h80, 8'h80);
      chk({7'h0, irq}, 8'h01);
      wr_reg(`ADDR_CONTROL, 8'h13);
      rd_reg(`ADDR_COUNT_LOWER, 8'h00, 8'h00);
      rd_reg(`ADDR_CONTROL, 8'h80, 8'h00);
      chk({7'h0, irq}, 8'h00);
   endtask
   task automatic t_width();
      wr_reg(`ADDR_PRESET, 8'h00);
      wait_n(6);
      rd_reg(`ADDR_COUNT_LOWER, 8'hff, 8'h20);
      @(posedge clk);
      pc <= 1'b1;
      wait_n(8);
      pc <= 1'b0;
      wait_n(8);
      rd_reg(`ADDR_COUNT_LOWER, 8'hff, 8'h18);
   endtask
   task automatic t_event();
      wr_reg(`ADDR_RELOAD_LOWER, 8'h05);
      wr_reg(`ADDR_CONTROL, 8'h02);
      wr_reg(`ADDR_PRESET, 8'h00);
      repeat (3) begin
         @(posedge clk);
         pc <= 1'b1;
         wait_n(4);
         pc <= 1'b0;
         wait_n(3);
      end
      wait_n(6);
      rd_reg(`ADDR_COUNT_LOWER, 8'hff, 8'h02);
   endtask
   task automatic t_edges();
      wr_reg(`ADDR_CONTROL, 8'h0b);
      @(posedge clk);
      pa <= 8'h01;
      wait_n(4);
      pa <= 8'h00;
      wait_n(8);
      rd_reg(`ADDR_CONTROL, 8'h60, 8'h40);
      chk({7'h0, irq}, 8'h01);
      wr_reg(`ADDR_CLR_RISE, 8'ha5);
      rd_reg(`ADDR_CONTROL, 8'h7f, 8'h0b);
      wr_reg(`ADDR_CONTROL, 8'h07);
      @(posedge clk);
      pa <= 8'h02;
      wait_n(8);
      rd_reg(`ADDR_CONTROL, 8'h60, 8'h20);
      chk({7'h0, irq}, 8'h01);
      wr_reg(`ADDR_CLR_FALL, 8'h5a);
      pa <= 8'h00;
      wait_n(8);
      rd_reg(`ADDR_CONTROL, 8'h7f, 8'h07);
   endtask
   task automatic t_pulse();
      logic b;
      wr_reg(`ADDR_PRESET, 8'h40);
      wr_reg(`ADDR_CONTROL, 8'h01);
      wait_n(2);
      #1;
      b = coe;
      wr_reg(`ADDR_PRESET, 8'h00);
      wait_n(1);
      #1;
      chk({7'h0, coe}, {7'h0, ~b});
   endtask
   task automatic stop_test();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #20000;
      errors++;
      stop_test();
   end
   initial begin
      {errors, check_count} = '0;
      {rst_n, wr, rd, pc, addr, wd, pa} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_ports();
      t_overflow();
      t_width();
      t_event();
      t_edges();
      t_pulse();
      stop_test();
   end
endmodule // tb_mcu_counter_edge_io
`default_nettype wire
